// [rbm_defs.vh]
// Constants for the reset and boot-mode control block
// Function
// - Processor cycle runs at the input clock rate.
// - Cycle clock is driven out unless the disable bit is set.
// - Later resets keep the clock running, no stabilisation wait.
// - Reset empties stacks, masks interrupts, clears mode status register.
// - Boot runs at release only without bus request and booting mode.
// - After boot, first fetch is internal program address zero.
// - Mode C strap sampled at reset; pin is general flag two afterwards.
// - Mode 000 boots 32 words by byte DMA, full memory mode.
// - Mode 010 no boot, starts at external address zero, full mode.
// - In no-boot mode byte DMA is software's, never auto or awaited.
// - Mode C one is host mode; BA 00 byte boot, 01 host boot.
// - Host boot holds execution until internal program word zero written.
// - Host mode, mode D zero: acknowledge actively driven.
// - Host mode, mode D one: acknowledge open-drain, board pull-down.
// - Full mode: 24-bit program memory, 48K on chip, two 8K overlays.
// - Host mode: no external execution, 16-bit bus, one overlay line.
// - At release interrupt servicing is enabled, masks stay set.
`ifndef RBM_DEFS_VH
`define RBM_DEFS_VH

// Register map, byte addresses
`define RBM_ADDR_CTRL     12'h000
`define RBM_ADDR_STATUS   12'h004
`define RBM_ADDR_MODE     12'h008
`define RBM_ADDR_BOOTCNT  12'h00c

// Control register fields
`define RBM_CTRL_CLKDIS   0
`define RBM_CTRL_BUSREQ   1
`define RBM_CTRL_WIDTH    2
`define RBM_CTRL_RESET    2'h0

// Boot sequencing figures
`define RBM_BOOT_WORDS    6'h20
`define RBM_START_ADDR    14'h0000
`define RBM_CNT_W         6
`define RBM_IMASK_ALL     10'h3ff
`define RBM_IMASK_W       10
`define RBM_STACK_EMPTY   4'h0
`define RBM_MODE_STATUS_CLEAR 7'h00

// Memory geometry per mode
`define RBM_PM_WIDTH_FULL 5'h18
`define RBM_PM_WIDTH_HOST 5'h10
`define RBM_PM_WORDS_K    6'h30
`define RBM_OVL_LINES_FULL 2'h2
`define RBM_OVL_LINES_HOST 2'h1

// Strap codes for mode C,B,A
`define RBM_MODE_BYTE_FULL 3'h0
`define RBM_MODE_NOBOOT    3'h2
`define RBM_MODE_BYTE_HOST 3'h4
`define RBM_MODE_HOST_DMA  3'h5

`endif

// [rbm_clkdiv.v]
// Cycle clock enable and cycle clock output generator
`timescale 1ns/100ps
module rbm_clkdiv (
	// Clock and reset
	input  wire clk_in,
	input  wire rst_in,
	// Control
	input  wire disable_in,
	// Outputs
	output reg  cycle_en_out,
	output reg  cycle_clock_output_out
);

	// Every rising edge of clk_in is one processor cycle, so the enable stays high.
	// Reset only parks the pin output low; the internal cycle never stops,
	// and parking it avoids an unknown level before the first write.
	always @(posedge clk_in) begin
		if (rst_in) begin
			cycle_en_out           <= 1'b1;
			cycle_clock_output_out <= 1'b0;
		end else begin
			cycle_en_out <= 1'b1;
			if (disable_in)
				cycle_clock_output_out <= 1'b0;
			else
				cycle_clock_output_out <= ~cycle_clock_output_out;
		end
	end

endmodule

// [rbm_ctrl.v]
// Reset, clock output and boot-mode control with APB register slave
//
// Decided for this implementation: the register offsets and the APB register port.
`include "rbm_defs.vh"
`timescale 1ns/100ps
module rbm_ctrl #(
	parameter BOOT_WORDS = 32
) (
	// Clock and reset
	input  wire        clk_in,
	input  wire        rst_in,
	// APB slave
	input  wire        psel_in,
	input  wire        penable_in,
	input  wire        pwrite_in,
	input  wire [11:0] paddr_in,
	input  wire [31:0] pwdata_in,
	output wire        pready_out,
	output wire        pslverr_out,
	output reg  [31:0] prdata_out,
	// Mode straps, mode C shares the general flag two pin
	input  wire        mode_a_in,
	input  wire        mode_b_in,
	input  wire        mode_d_in,
	input  wire        general_flag_two_in,
	output reg         general_flag_two_out,
	output reg         general_flag_two_oe_n_out,
	input  wire        flag_two_dir_in,
	input  wire        flag_two_val_in,
	// System hooks
	input  wire        bus_request_in,
	input  wire        boot_word_done_in,
	input  wire        pm_zero_written_in,
	// Boot and memory status
	output reg         byte_memory_dma_start_out,
	output reg         host_port_dma_wait_out,
	output reg         run_out,
	output reg  [13:0] fetch_addr_out,
	output reg         fetch_external_out,
	output reg         host_mode_out,
	output reg  [4:0]  pm_width_out,
	output reg  [5:0]  pm_words_k_out,
	output reg  [1:0]  overlay_lines_out,
	output reg         ext_exec_allowed_out,
	// Core state set by reset
	output reg  [3:0]  stack_ptr_out,
	output reg  [9:0]  interrupt_mask_out,
	output reg         interrupt_enable_out,
	output reg  [6:0]  mode_status_register_out,
	// Host DMA acknowledge, open-drain capable
	input  wire        ack_req_in,
	output reg         host_dma_acknowledge_out,
	output reg         host_dma_acknowledge_oe_n_out,
	// Clock output
	output wire        cycle_clock_output_out
);

	// State codes, one-hot
	localparam ST_RESET = 4'h1;
	localparam ST_BOOT  = 4'h2;
	localparam ST_WAIT  = 4'h4;
	localparam ST_RUN   = 4'h8;

	reg  [3:0]                 state;
	reg  [3:0]                 next_state;
	reg  [`RBM_CTRL_WIDTH-1:0] ctrl;
	reg  [3:0]                 strap;      // D,C,B,A
	reg  [`RBM_CNT_W-1:0]      boot_cnt;
	reg                        rst_d;
	reg  [4:0]                 sync_1;
	reg  [4:0]                 sync_2;
	wire                       cycle_en;
	wire                       wr;
	wire                       rd;

	// Straps and bus request come from pins, two flops before use
	always @(posedge clk_in) begin
		sync_1 <= {mode_d_in, general_flag_two_in, mode_b_in, mode_a_in,
			bus_request_in};
		sync_2 <= sync_1;
	end

	// Release edge detector for the reset
	always @(posedge clk_in) begin
		rst_d <= rst_in;
	end

	// Decode of a latched mode code into a booting flag
	function is_boot;
		input [3:0] s;
		begin
			is_boot = (s[2:0] == `RBM_MODE_BYTE_FULL) ||
				(s[2:0] == `RBM_MODE_BYTE_HOST) ||
				(s[2:0] == `RBM_MODE_HOST_DMA);
		end
	endfunction

	// Straps caught on the first clock after release, kept until next reset
	always @(posedge clk_in) begin
		if (rst_in)
			strap <= 4'h0;
		else if (rst_d)
			strap <= sync_2[4:1];
	end

	rbm_clkdiv u_clkdiv (
		.clk_in                 (clk_in),
		.rst_in                 (rst_in),
		.disable_in             (ctrl[`RBM_CTRL_CLKDIS]),
		.cycle_en_out           (cycle_en),
		.cycle_clock_output_out (cycle_clock_output_out)
	);

	// APB decode; zero wait states, unmapped reads give zero
	assign wr          = psel_in & penable_in & pwrite_in;
	assign rd          = psel_in & ~pwrite_in;
	assign pready_out  = 1'b1;
	assign pslverr_out = 1'b0;

	// Control register, cleared to zero by reset; sync flops are not reset
	always @(posedge clk_in) begin
		if (rst_in)
			ctrl <= `RBM_CTRL_RESET;
		else if (wr && paddr_in == `RBM_ADDR_CTRL)
			ctrl <= pwdata_in[`RBM_CTRL_WIDTH-1:0];
	end

	// Read mux registered in the setup cycle
	always @(posedge clk_in) begin
		if (rst_in)
			prdata_out <= 32'h0;
		else if (rd && !penable_in) begin
			case (paddr_in)
			`RBM_ADDR_CTRL:    prdata_out <= {30'h0, ctrl};
			`RBM_ADDR_STATUS:  prdata_out <= {28'h0, state};
			`RBM_ADDR_MODE:    prdata_out <= {28'h0, strap};
			`RBM_ADDR_BOOTCNT: prdata_out <= {26'h0, boot_cnt};
			default:           prdata_out <= 32'h0;
			endcase
		end
	end

	// Boot sequencer next state
	always @* begin
		next_state = state;
		case (state)
		ST_RESET: begin
			if (rst_d) begin
				next_state = ST_RESET;
			end else if (ctrl[`RBM_CTRL_BUSREQ] || sync_2[0] || !is_boot(strap)) begin
				next_state = ST_RUN;
			end else if (strap[2:0] == `RBM_MODE_HOST_DMA) begin
				next_state = ST_WAIT;
			end else begin
				next_state = ST_BOOT;
			end
		end
		ST_BOOT: begin
			if (cycle_en && boot_word_done_in &&
				boot_cnt == BOOT_WORDS[`RBM_CNT_W-1:0] - 6'h1)
				next_state = ST_RUN;
		end
		ST_WAIT: begin
			if (pm_zero_written_in)
				next_state = ST_RUN;
		end
		ST_RUN: next_state = ST_RUN;
		default: next_state = ST_RESET;
		endcase
	end

	// Sequencer registers and boot word counter
	always @(posedge clk_in) begin
		if (rst_in) begin
			state    <= ST_RESET;
			boot_cnt <= {`RBM_CNT_W{1'b0}};
		end else begin
			state <= next_state;
			if (state == ST_BOOT && cycle_en && boot_word_done_in)
				boot_cnt <= boot_cnt + 6'h1;
		end
	end

	// Core state on master reset and at release
	always @(posedge clk_in) begin
		if (rst_in) begin
			stack_ptr_out            <= `RBM_STACK_EMPTY;
			interrupt_mask_out       <= `RBM_IMASK_ALL;
			mode_status_register_out <= `RBM_MODE_STATUS_CLEAR;
			interrupt_enable_out     <= 1'b0;
		end else begin
			interrupt_enable_out <= 1'b1;
		end
	end

	// Boot and memory outputs, all registered
	always @(posedge clk_in) begin
		if (rst_in) begin
			byte_memory_dma_start_out <= 1'b0;
			host_port_dma_wait_out    <= 1'b0;
			run_out                   <= 1'b0;
			fetch_addr_out            <= `RBM_START_ADDR;
			fetch_external_out        <= 1'b0;
			host_mode_out             <= 1'b0;
			pm_width_out              <= `RBM_PM_WIDTH_FULL;
			pm_words_k_out            <= `RBM_PM_WORDS_K;
			overlay_lines_out         <= `RBM_OVL_LINES_FULL;
			ext_exec_allowed_out      <= 1'b1;
		end else begin
			byte_memory_dma_start_out <= (state == ST_RESET) && (next_state == ST_BOOT);
			host_port_dma_wait_out    <= (next_state == ST_WAIT);
			run_out                   <= (next_state == ST_RUN);
			fetch_addr_out            <= `RBM_START_ADDR;
			// Only the no-boot mode starts outside the chip
			fetch_external_out        <= (next_state == ST_RUN) &&
				(strap[2:0] == `RBM_MODE_NOBOOT) && (state != ST_BOOT);
			host_mode_out             <= strap[2];
			pm_width_out              <= strap[2] ? `RBM_PM_WIDTH_HOST :
				`RBM_PM_WIDTH_FULL;
			pm_words_k_out            <= `RBM_PM_WORDS_K;
			overlay_lines_out         <= strap[2] ? `RBM_OVL_LINES_HOST :
				`RBM_OVL_LINES_FULL;
			ext_exec_allowed_out      <= ~strap[2];
		end
	end

	// Flag two pin: never driven during reset so the strap can be read
	always @(posedge clk_in) begin
		if (rst_in) begin
			general_flag_two_out      <= 1'b0;
			general_flag_two_oe_n_out <= 1'b1;
		end else begin
			general_flag_two_out      <= flag_two_val_in;
			general_flag_two_oe_n_out <= ~flag_two_dir_in;
		end
	end

	// Acknowledge: driven both ways, or only high when open-drain in host mode
	always @(posedge clk_in) begin
		if (rst_in) begin
			host_dma_acknowledge_out      <= 1'b1;
			host_dma_acknowledge_oe_n_out <= 1'b1;
		end else if (strap[2] && strap[3]) begin
			// Board pull-down gives the low level, so only high is driven
			host_dma_acknowledge_out      <= 1'b1;
			host_dma_acknowledge_oe_n_out <= ack_req_in;
		end else begin
			host_dma_acknowledge_out      <= ~ack_req_in;
			host_dma_acknowledge_oe_n_out <= 1'b0;
		end
	end

endmodule

// [rbm_ctrl_monitor.sv]
// Concurrent checks on the reset and boot-mode control ports
`timescale 1ns/100ps
module rbm_ctrl_monitor (
	// Clock and reset
	input wire logic       clk_in,
	input wire logic       rst_in,
	// Watched ports
	input wire logic       pm_zero_written_in,
	input wire logic       byte_memory_dma_start_out,
	input wire logic       host_port_dma_wait_out,
	input wire logic       run_out,
	input wire logic       host_mode_out,
	input wire logic [4:0] pm_width_out,
	input wire logic [1:0] overlay_lines_out,
	input wire logic [3:0] stack_ptr_out,
	input wire logic [9:0] interrupt_mask_out,
	input wire logic       interrupt_enable_out,
	input wire logic [6:0] mode_status_register_out,
	input wire logic       general_flag_two_oe_n_out
);
	// Reset checks carry their own disable so they still see reset edges
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	a_reset_core_vals: assert property (disable iff (1'b0) rst_in |=> stack_ptr_out == 4'h0
		&& interrupt_mask_out == 10'h3ff && mode_status_register_out == 7'h0 && !interrupt_enable_out)
		else $error("core state not cleared by reset");
	a_ints_on_release: assert property ($fell(rst_in) |=> interrupt_enable_out)
		else $error("interrupt servicing off after release");
	a_masks_kept: assert property (interrupt_enable_out |-> interrupt_mask_out == 10'h3ff)
		else $error("masks changed after release");
	a_host_hold: assert property (host_port_dma_wait_out |-> !run_out)
		else $error("running while host boot pending");
	a_host_release: assert property (host_port_dma_wait_out && pm_zero_written_in |-> ##[1:4] run_out)
		else $error("no run after word zero written");
	a_mem_geom: assert property (run_out |-> pm_width_out == (host_mode_out ? 5'h10 : 5'h18)
		&& overlay_lines_out == (host_mode_out ? 2'h1 : 2'h2))
		else $error("memory geometry wrong for mode");
	a_flag_off_reset: assert property (disable iff (1'b0) rst_in |=> general_flag_two_oe_n_out)
		else $error("flag pin driven during reset");
	a_boot_holds: assert property (byte_memory_dma_start_out |-> !run_out)
		else $error("running at byte boot start");
	// Main scenarios reached
	cover property ($rose(run_out) && host_mode_out);
	cover property (byte_memory_dma_start_out);
	cover property (host_port_dma_wait_out && pm_zero_written_in);
endmodule
bind rbm_ctrl rbm_ctrl_monitor u_mon (.clk_in, .rst_in, .pm_zero_written_in,
	.byte_memory_dma_start_out, .host_port_dma_wait_out, .run_out, .host_mode_out,
	.pm_width_out, .overlay_lines_out, .stack_ptr_out, .interrupt_mask_out,
	.interrupt_enable_out, .mode_status_register_out, .general_flag_two_oe_n_out);

// [rbm_board.sv]
// Board model: mode straps, gated mode C driver, acknowledge pull-down
`timescale 1ns/100ps
module rbm_board (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	// Strap levels D,C,B,A and device pin drives
	input  wire logic [3:0] strap_in,
	input  wire logic       flag_drv_in,
	input  wire logic       flag_oe_n_in,
	input  wire logic       ack_drv_in,
	input  wire logic       ack_oe_n_in,
	// Resolved pin levels
	output wire logic       mode_a_out,
	output wire logic       mode_b_out,
	output wire logic       mode_d_out,
	output wire logic       flag_pin_out,
	output wire logic       ack_pin_out
);
	logic last = 1'b0;
	// Resistor straps
	assign mode_a_out = strap_in[0];
	assign mode_b_out = strap_in[1];
	assign mode_d_out = strap_in[3];
	// Driver only in reset; a floating pin toggles so no stale level passes
	assign flag_pin_out = rst_in ? strap_in[2] : (!flag_oe_n_in ? flag_drv_in : ~last);
	assign ack_pin_out = !ack_oe_n_in ? ack_drv_in : 1'b0;
	// Last seen pin level
	always @(posedge clk_in) begin
		last <= flag_pin_out;
	end
endmodule

// [rbm_ctrl_tb.sv]
// Self-checking bench for the reset and boot-mode control block
`timescale 1ns/100ps
module rbm_ctrl_tb;
	localparam BW = 4;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic psel_in, penable_in, pwrite_in;
	logic [11:0] paddr_in;
	logic [31:0] pwdata_in, rd;
	logic [31:0] rs = 32'd52284;
	logic [3:0] strap;
	logic flag_two_dir_in, flag_two_val_in, bus_request_in, boot_word_done_in, pm_zero_written_in;
	logic ack_req_in = 1'b0, ack_prev = 1'b0;
	logic c;
	wire pready_out, pslverr_out, mode_a_in, mode_b_in, mode_d_in, general_flag_two_in;
	wire general_flag_two_out, general_flag_two_oe_n_out, byte_memory_dma_start_out;
	wire host_port_dma_wait_out, run_out, fetch_external_out, host_mode_out, ack_pin;
	wire ext_exec_allowed_out, interrupt_enable_out, cycle_clock_output_out;
	wire host_dma_acknowledge_out, host_dma_acknowledge_oe_n_out;
	wire [31:0] prdata_out;
	wire [13:0] fetch_addr_out;
	wire [4:0] pm_width_out;
	wire [5:0] pm_words_k_out;
	wire [1:0] overlay_lines_out;
	wire [3:0] stack_ptr_out;
	wire [9:0] interrupt_mask_out;
	wire [6:0] mode_status_register_out;
	int miscompares = 0, n_compared = 0, cyc = 0, nst = 0;
	logic [3:0] modes [6] = '{4'h0, 4'h2, 4'h4, 4'h5, 4'hc, 4'hd};
	rbm_ctrl #(.BOOT_WORDS(BW)) u_rbm_ctrl (.clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in,
		.paddr_in, .pwdata_in, .pready_out, .pslverr_out, .prdata_out, .mode_a_in, .mode_b_in,
		.mode_d_in, .general_flag_two_in, .general_flag_two_out, .general_flag_two_oe_n_out,
		.flag_two_dir_in, .flag_two_val_in, .bus_request_in, .boot_word_done_in,
		.pm_zero_written_in, .byte_memory_dma_start_out, .host_port_dma_wait_out, .run_out,
		.fetch_addr_out, .fetch_external_out, .host_mode_out, .pm_width_out, .pm_words_k_out,
		.overlay_lines_out, .ext_exec_allowed_out, .stack_ptr_out, .interrupt_mask_out,
		.interrupt_enable_out, .mode_status_register_out, .ack_req_in, .host_dma_acknowledge_out,
		.host_dma_acknowledge_oe_n_out, .cycle_clock_output_out);
	rbm_board u_rbm_board (.clk_in, .rst_in, .strap_in(strap), .flag_drv_in(general_flag_two_out),
		.flag_oe_n_in(general_flag_two_oe_n_out), .ack_drv_in(host_dma_acknowledge_out),
		.ack_oe_n_in(host_dma_acknowledge_oe_n_out), .mode_a_out(mode_a_in),
		.mode_b_out(mode_b_in), .mode_d_out(mode_d_in), .flag_pin_out(general_flag_two_in),
		.ack_pin_out(ack_pin));
	// Steady clock, never stopped
	always #20 clk_in = ~clk_in;
	// Random acknowledge requests, start pulse count, hang limit
	always @(posedge clk_in) begin
		ack_req_in <= xs() & 1;
		ack_prev <= ack_req_in;
		if (byte_memory_dma_start_out === 1'b1) nst++;
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			final_report;
		end
	end
	function automatic logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	// Expected boot kind: 0 none, 1 byte DMA, 2 host DMA
	function automatic int kind(input logic [3:0] s);
		if (s[1:0] == 2'h0 && s[2:1] != 2'h1) return 1;
		if (s[2:0] == 3'h5) return 2;
		return 0;
	endfunction
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Hold request until pready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		do @(posedge clk_in); while (pready_out !== 1'b1);
		rd = prdata_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		@(posedge clk_in);
	endtask
	task pulse(input bit h);
		if (h) pm_zero_written_in <= 1'b1;
		else boot_word_done_in <= 1'b1;
		@(posedge clk_in);
		pm_zero_written_in <= 1'b0;
		boot_word_done_in <= 1'b0;
		@(posedge clk_in);
	endtask
	task run_mode(input logic [3:0] s, input logic b);
		int k;
		k = b ? 0 : kind(s);
		strap <= s;
		bus_request_in <= b;
		flag_two_dir_in <= 1'b0;
		rst_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		chk(stack_ptr_out, 0);
		chk(interrupt_mask_out, 10'h3ff);
		chk(mode_status_register_out, 0);
		chk(general_flag_two_oe_n_out, 1);
		nst = 0;
		rst_in <= 1'b0;
		repeat (5) @(posedge clk_in);
		chk(interrupt_enable_out, 1);
		chk(nst, k == 1);
		chk(run_out, k == 0);
		chk(host_mode_out, s[2]);
		chk(pm_width_out, s[2] ? 5'h10 : 5'h18);
		chk(overlay_lines_out, s[2] ? 2'h1 : 2'h2);
		chk(ext_exec_allowed_out, !s[2]);
		if (!s[2]) chk(pm_words_k_out, 6'h30);
		if (s[2:0] == 3'h2) chk(fetch_external_out, 1);
		if (s[2] && !s[3]) chk(host_dma_acknowledge_oe_n_out, 0);
		if (k == 1) begin
			repeat (BW - 1) pulse(0);
			chk(run_out, 0);
			pulse(0);
		end
		if (k == 2) begin
			chk(host_port_dma_wait_out, 1);
			chk(run_out, 0);
			pulse(1);
		end
		for (int i = 0; i < 8 && run_out !== 1'b1; i++) @(posedge clk_in);
		chk(run_out, 1);
		chk(fetch_addr_out, 0);
		if (k != 0) chk(fetch_external_out, 0);
		flag_two_dir_in <= 1'b1;
		flag_two_val_in <= xs() & 1;
		repeat (4) @(posedge clk_in);
		chk(general_flag_two_out, flag_two_val_in);
		chk(general_flag_two_oe_n_out, 0);
		chk(ack_pin, !ack_prev);
		if (s[2] && s[3]) chk(host_dma_acknowledge_oe_n_out, ack_prev);
		apb(0, 12'h008, 0);
		chk(rd, s);
		apb(0, 12'h004, 0);
		chk(rd, 32'h8);
		if (k == 1) begin
			apb(0, 12'h00c, 0);
			chk(rd, BW);
		end
	endtask
	// Main sequence: each defined strap code, a bus request, then clock output
	initial begin
		{psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = 0;
		{flag_two_dir_in, flag_two_val_in, bus_request_in, boot_word_done_in} = 0;
		pm_zero_written_in = 1'b0;
		strap = 4'h0;
		repeat (20) @(posedge clk_in);
		foreach (modes[i]) run_mode(modes[i], 1'b0);
		run_mode(4'h0, 1'b1);
		apb(1, 12'h000, xs() & 32'hfffffffc | 32'h1);
		repeat (3) @(posedge clk_in);
		chk(cycle_clock_output_out, 0);
		@(posedge clk_in);
		chk(cycle_clock_output_out, 0);
		apb(0, 12'h000, 0);
		chk(rd, 1);
		apb(1, 12'h000, 32'h2);
		repeat (3) @(posedge clk_in);
		c = cycle_clock_output_out;
		@(posedge clk_in);
		chk(cycle_clock_output_out, !c);
		// Forced bus request only acts at release, the sequencer stays running
		apb(0, 12'h000, 0);
		chk(rd, 32'h2);
		apb(0, 12'h004, 0);
		chk(rd, 32'h8);
		// Unmapped place reads as zero, never an error
		apb(0, 12'h010, 0);
		chk(rd, 0);
		chk(pslverr_out, 0);
		final_report;
	end
	task final_report;
		if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
endmodule
